//--- inc/pir_pkg.sv
package pir_pkg;

    localparam int CLK_HZ = 100_000_000;

    // pulse length is a fixed number of oscillator ticks; trim moves the tick period
    localparam int PULSE_TICKS = 1000;
    localparam int PULSE_MIN_MS = 400;
    localparam int PULSE_MAX_MS = 7500;
    localparam int OSC_MIN_CYCLES = int'((longint'(PULSE_MIN_MS) * CLK_HZ / 1000) / PULSE_TICKS);
    localparam int OSC_MAX_CYCLES = int'((longint'(PULSE_MAX_MS) * CLK_HZ / 1000) / PULSE_TICKS);
    localparam int PER_W = 20;
    localparam int TRIM_W = 8;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;
    localparam logic [TRIM_W-1:0] TRIM_FULL = 8'hFF;

    // linear map of the trim setting onto the oscillator period
    function automatic logic [PER_W-1:0] osc_period(input logic [TRIM_W-1:0] trim,
                                                   input logic [PER_W-1:0] pmin,
                                                   input logic [PER_W-1:0] pmax);
        logic [31:0] span;
        span = 32'(pmax - pmin) * 32'(trim) / 32'(TRIM_FULL);
        return pmin + span[PER_W-1:0];
    endfunction

    localparam int STARTUP_TIME_S = 120;
    localparam int STARTUP_TICKS = int'(longint'(STARTUP_TIME_S) * CLK_HZ /
        longint'(osc_period(TRIM_RESET, PER_W'(OSC_MIN_CYCLES), PER_W'(OSC_MAX_CYCLES))));
    localparam int START_W = 16;
    localparam int BLINK_TICKS = 64;
    localparam int PULSE_W = 12;

    localparam int DUAL_WINDOW_MS = 1000;
    localparam int DUAL_WINDOW_CYCLES = int'(longint'(DUAL_WINDOW_MS) * CLK_HZ / 1000);
    localparam int WIN_W = 32;

    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TRIM = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    localparam int CTRL_DUAL = 0;
    localparam int CTRL_LAMP_CUT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    localparam int ST_BIT_FLAG = 0;
    localparam int ST_BIT_STARTUP = 1;
    localparam int ST_BIT_LAMP = 2;

    localparam int EV_W = 3;
    localparam int EV_TRIG = 0;
    localparam int EV_END = 1;
    localparam int EV_READY = 2;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {ST_STARTUP, ST_IDLE, ST_PULSE} trig_state_t;

endpackage

//--- inc/osc_if.sv
`timescale 1ns/1ps
interface osc_if;
    logic [pir_pkg::TRIM_W-1:0] timing_trim;
    logic restart;
    logic tick;

    modport ctl (output timing_trim, output restart, input tick);
    modport osc (input timing_trim, input restart, output tick);
endinterface

//--- design/trim_osc.sv
`timescale 1ns/1ps
module trim_osc
#(
    parameter logic [pir_pkg::PER_W-1:0] PMIN = pir_pkg::PER_W'(pir_pkg::OSC_MIN_CYCLES),
    parameter logic [pir_pkg::PER_W-1:0] PMAX = pir_pkg::PER_W'(pir_pkg::OSC_MAX_CYCLES)
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // controller side
    osc_if.osc port
);
    import pir_pkg::*;

    logic [PER_W-1:0] count;
    logic [PER_W-1:0] period;
    logic wrap;

    // period follows the trim live, so turning it mid-pulse bends the pulse
    assign period = osc_period(port.timing_trim, PMIN, PMAX);
    assign wrap = (count >= period - PER_W'(1));

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            count <= '0;
            port.tick <= 1'b0;
        end
        else
        begin
            count <= (port.restart || wrap) ? '0 : count + PER_W'(1);
            port.tick <= wrap && !port.restart;
        end
    end
endmodule

//--- design/pir_motion_trigger_logic.sv
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
//
// Notes on behaviour
// - motion_flag_pin is high only while a detection is reported, low otherwise.
// - after start-up the lamp follows motion_flag_pin exactly while the lamp cut bit is clear.
// - start-up period after reset, length scales with timing_trim, about two minutes at factory trim.
// - lamp cut jumper open darkens lamp normally; lamp still blinks during start-up.
// - pulse high time is counted in oscillator ticks; longer period gives longer pulse.
// - fastest trim gives roughly 400 ms pulse.
// - slowest trim gives roughly 7.5 s pulse, linear between the extremes.
// - mode switch selects single-pulse or dual-pulse detection.
// - single-pulse: crossing either limit starts a pulse.
// - dual-pulse: upper and lower crossings both needed within a fixed window.
module pir_motion_trigger_logic
#(
    parameter logic [pir_pkg::PER_W-1:0] OSC_MIN = pir_pkg::PER_W'(pir_pkg::OSC_MIN_CYCLES),
    parameter logic [pir_pkg::PER_W-1:0] OSC_MAX = pir_pkg::PER_W'(pir_pkg::OSC_MAX_CYCLES),
    parameter logic [pir_pkg::START_W-1:0] STARTUP_TICKS = pir_pkg::START_W'(pir_pkg::STARTUP_TICKS),
    parameter logic [pir_pkg::WIN_W-1:0] DUAL_WINDOW = pir_pkg::WIN_W'(pir_pkg::DUAL_WINDOW_CYCLES),
    parameter logic RETRIGGER = 1'b1
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // window comparator results
    input wire logic ABOVE_UPPER,
    input wire logic BELOW_LOWER,
    // motion outputs
    output logic MOTION_FLAG_PIN,
    output logic MOTION_LAMP,
    output logic IRQ
);
    import pir_pkg::*;

    osc_if osc_bus ();

    trim_osc #(
        .PMIN(OSC_MIN),
        .PMAX(OSC_MAX)
    ) u_osc (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .port(osc_bus.osc)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // registers and bus slave

    logic [1:0] ctrl;
    logic [TRIM_W-1:0] timing_trim;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic [EV_W-1:0] events;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] dp_addr;
    logic [31:0] rd_mux;
    logic addr_ok;
    logic accept;
    logic [EV_W-1:0] w1c;

    trig_state_t state;
    trig_state_t next_state;

    assign accept = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    assign addr_ok = (HADDR[31:8] == 24'h000000);
    assign osc_bus.timing_trim = timing_trim;

    assign w1c = (wr_pend && dp_addr == ADDR_IRQ_STAT) ? HWDATA[EV_W-1:0] : '0;

    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (dp_addr)
            ADDR_CTRL: rd_mux[1:0] = ctrl;
            ADDR_TRIM: rd_mux[TRIM_W-1:0] = timing_trim;
            ADDR_STATUS: rd_mux[2:0] = {MOTION_LAMP, state == ST_STARTUP, MOTION_FLAG_PIN};
            ADDR_IRQ_STAT: rd_mux[EV_W-1:0] = irq_stat;
            ADDR_IRQ_MASK: rd_mux[EV_W-1:0] = irq_mask;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // writes finish with no wait; reads take one wait so they see a write just before
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= 8'h00;
            HREADYOUT <= 1'b1;
            HRDATA <= 32'h00000000;
        end
        else
        begin
            wr_pend <= accept && HWRITE;
            rd_pend <= accept && !HWRITE;
            if (accept)
            begin
                dp_addr <= addr_ok ? HADDR[7:0] : 8'hFF;
            end
            HREADYOUT <= !(accept && !HWRITE);
            if (rd_pend)
            begin
                HRDATA <= rd_mux;
            end
        end
    end

    assign HRESP = 1'b0;

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl <= CTRL_RESET;
            timing_trim <= TRIM_RESET;
            irq_mask <= MASK_RESET;
        end
        else if (wr_pend)
        begin
            if (dp_addr == ADDR_CTRL)
            begin
                ctrl <= HWDATA[1:0];
            end
            if (dp_addr == ADDR_TRIM)
            begin
                timing_trim <= HWDATA[TRIM_W-1:0];
            end
            if (dp_addr == ADDR_IRQ_MASK)
            begin
                irq_mask <= HWDATA[EV_W-1:0];
            end
        end
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_stat <= '0;
            IRQ <= 1'b0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~w1c) | events;
            IRQ <= |(((irq_stat & ~w1c) | events) & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // crossing detection

    logic above_q;
    logic below_q;
    logic cross_up;
    logic cross_dn;
    logic arm_up;
    logic arm_dn;
    logic [WIN_W-1:0] win_cnt;
    logic win_open;
    logic dual_hit;
    logic hit;

    assign cross_up = ABOVE_UPPER && !above_q;
    assign cross_dn = BELOW_LOWER && !below_q;
    assign win_open = (win_cnt != '0);
    // opposite crossing inside the window qualifies
    assign dual_hit = win_open && ((cross_up && arm_dn) || (cross_dn && arm_up));
    assign hit = ctrl[CTRL_DUAL] ? dual_hit : (cross_up || cross_dn);

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            above_q <= 1'b0;
            below_q <= 1'b0;
            arm_up <= 1'b0;
            arm_dn <= 1'b0;
            win_cnt <= '0;
        end
        else
        begin
            above_q <= ABOVE_UPPER;
            below_q <= BELOW_LOWER;
            if (dual_hit || (!win_open && !cross_up && !cross_dn))
            begin
                arm_up <= 1'b0;
                arm_dn <= 1'b0;
                win_cnt <= '0;
            end
            else if ((cross_up && !arm_up) || (cross_dn && !arm_dn))
            begin
                // a fresh first crossing opens the fixed window
                arm_up <= cross_up;
                arm_dn <= cross_dn;
                win_cnt <= DUAL_WINDOW;
            end
            else if (win_open)
            begin
                win_cnt <= win_cnt - WIN_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // start-up, pulse timing and outputs

    logic [START_W-1:0] start_cnt;
    logic [START_W-1:0] next_start_cnt;
    logic [PULSE_W-1:0] pulse_cnt;
    logic [PULSE_W-1:0] next_pulse_cnt;
    logic [6:0] blink_cnt;
    logic blink;
    logic next_flag;
    logic restart;

    always_comb
    begin
        next_state = state;
        next_start_cnt = start_cnt;
        next_pulse_cnt = pulse_cnt;
        restart = 1'b0;
        events = '0;
        unique case (state)
            ST_STARTUP:
            begin
                // ticks stretch with the trim, so does start-up
                if (osc_bus.tick)
                begin
                    next_start_cnt = start_cnt - START_W'(1);
                    if (start_cnt <= START_W'(1))
                    begin
                        next_state = ST_IDLE;
                        events[EV_READY] = 1'b1;
                    end
                end
            end
            ST_IDLE:
            begin
                if (hit)
                begin
                    next_state = ST_PULSE;
                    next_pulse_cnt = PULSE_W'(PULSE_TICKS);
                    restart = 1'b1;
                    events[EV_TRIG] = 1'b1;
                end
            end
            ST_PULSE:
            begin
                if (hit && RETRIGGER)
                begin
                    next_pulse_cnt = PULSE_W'(PULSE_TICKS);
                    restart = 1'b1;
                    events[EV_TRIG] = 1'b1;
                end
                else if (osc_bus.tick)
                begin
                    next_pulse_cnt = pulse_cnt - PULSE_W'(1);
                    if (pulse_cnt <= PULSE_W'(1))
                    begin
                        next_state = ST_IDLE;
                        events[EV_END] = 1'b1;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    assign osc_bus.restart = restart;
    assign next_flag = (next_state == ST_PULSE);
    assign blink = (blink_cnt == 7'(BLINK_TICKS - 1)) && osc_bus.tick;

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state <= ST_STARTUP;
            start_cnt <= '0;
            pulse_cnt <= '0;
            blink_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            start_cnt <= (state == ST_STARTUP && start_cnt == '0) ? STARTUP_TICKS : next_start_cnt;
            pulse_cnt <= next_pulse_cnt;
            blink_cnt <= blink ? '0 : blink_cnt + 7'(osc_bus.tick);
        end
    end

    // after start-up, flag and lamp share one next value so they change on the same edge
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            MOTION_FLAG_PIN <= 1'b0;
            MOTION_LAMP <= 1'b0;
        end
        else
        begin
            MOTION_FLAG_PIN <= next_flag;
            if (next_state == ST_STARTUP)
            begin
                MOTION_LAMP <= MOTION_LAMP ^ blink;
            end
            else
            begin
                MOTION_LAMP <= next_flag && !ctrl[CTRL_LAMP_CUT];
            end
        end
    end
endmodule

//--- dv/pir_chk.sv
`timescale 1ns/1ps
module pir_chk
#(
    parameter logic [pir_pkg::PER_W-1:0] OSC_MIN = pir_pkg::PER_W'(pir_pkg::OSC_MIN_CYCLES)
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    // motion
    input wire logic ABOVE_UPPER,
    input wire logic BELOW_LOWER,
    input wire logic MOTION_FLAG_PIN,
    input wire logic MOTION_LAMP,
    input wire logic IRQ
);
    import pir_pkg::*;
    localparam int MIN_LEN = PULSE_TICKS * int'(OSC_MIN);
    logic tk;
    logic wp;
    logic seen;
    logic [7:0] wa;
    logic [1:0] ctl;
    logic [EV_W-1:0] msk;
    int cq;
    int hi;
    assign tk = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
    ////////////////////////////////////////////////////////////////
    // shadow config; cq lets a write settle before it is trusted
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wp <= 1'h0;
            wa <= 8'h0;
            ctl <= CTRL_RESET;
            msk <= MASK_RESET;
            cq <= 0;
            seen <= 1'h0;
            hi <= 0;
        end
        else
        begin
            wp <= tk && HWRITE && HADDR[31:8] == 24'h0;
            wa <= HADDR[7:0];
            if (wp && wa == ADDR_CTRL)
                ctl <= HWDATA[1:0];
            if (wp && wa == ADDR_IRQ_MASK)
                msk <= HWDATA[EV_W-1:0];
            cq <= wp ? 0 : (cq < 7 ? cq + 1 : cq);
            // a pulse can only start once start-up is over
            seen <= seen | MOTION_FLAG_PIN;
            hi <= MOTION_FLAG_PIN ? hi + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    chk_read_wait: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (tk && HWRITE |=> HREADYOUT)
        else $error("write stalled");
    chk_flag_cause: assert property ($rose(MOTION_FLAG_PIN) |-> $past(ABOVE_UPPER) || $past(BELOW_LOWER) ||
        $past(ABOVE_UPPER, 2) || $past(BELOW_LOWER, 2))
        else $error("flag rose without crossing");
    chk_single_rise: assert property (seen && cq > 2 && !ctl[CTRL_DUAL] && !MOTION_FLAG_PIN &&
        ($rose(ABOVE_UPPER) || $rose(BELOW_LOWER)) |-> ##[1:2] MOTION_FLAG_PIN)
        else $error("single crossing missed");
    chk_pulse_min: assert property ($fell(MOTION_FLAG_PIN) |-> hi >= MIN_LEN)
        else $error("pulse too short");
    chk_lamp_follow: assert property (seen && MOTION_LAMP |-> MOTION_FLAG_PIN)
        else $error("lamp lit without flag");
    chk_lamp_cut: assert property (seen && cq > 2 && ctl[CTRL_LAMP_CUT] |-> !MOTION_LAMP)
        else $error("lamp lit with jumper open");
    chk_irq_masked: assert property (cq > 2 && msk == MASK_RESET |-> !IRQ)
        else $error("irq with all masked");
endmodule
bind pir_motion_trigger_logic pir_chk #(.OSC_MIN(OSC_MIN)) i_chk (.CLOCK(CLOCK), .RST_N(RST_N), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
    .ABOVE_UPPER(ABOVE_UPPER), .BELOW_LOWER(BELOW_LOWER), .MOTION_FLAG_PIN(MOTION_FLAG_PIN),
    .MOTION_LAMP(MOTION_LAMP), .IRQ(IRQ));

//--- dv/mcu_reader.sv
`timescale 1ns/1ps
module mcu_reader
(
    // pin side
    input wire logic clock,
    input wire logic flag,
    // results
    output int pulses,
    output int len
);
    int run = 0;
    int count = 0;
    int last = 0;
    // one driver per result: the ports only mirror the counters
    assign pulses = count;
    assign len = last;
    // polls the pin each clock, as firmware would; high means motion
    always @(posedge clock)
    begin
        if (flag === 1'h1)
            run <= run + 1;
        else if (run > 0)
        begin
            last <= run;
            count <= count + 1;
            run <= 0;
        end
    end
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
    import pir_pkg::*;
    localparam logic [PER_W-1:0] OMIN = 20'h4;
    localparam logic [PER_W-1:0] OMAX = 20'h14;
    localparam int STT = 130;
    logic CLOCK = 1'h0;
    logic RST_N = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic au = 1'h0;
    logic bl = 1'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic flag;
    logic lamp;
    logic irq;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0 = 0;
    int pulses;
    int len;
    always #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK)
        cyc <= cyc + 1;
    pir_motion_trigger_logic #(.OSC_MIN(OMIN), .OSC_MAX(OMAX), .STARTUP_TICKS(START_W'(STT)),
        .DUAL_WINDOW(32'h32), .RETRIGGER(1'h1)) i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .ABOVE_UPPER(au), .BELOW_LOWER(bl),
        .MOTION_FLAG_PIN(flag), .MOTION_LAMP(lamp), .IRQ(irq));
    mcu_reader i_mcu (.clock(CLOCK), .flag(flag), .pulses(pulses), .len(len));
    ////////////////////////////////////////////////////////////////
    task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'h1)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        rng(got, exp, exp);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge CLOCK);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        for (n = 0; n < 2; n++)
        begin
            // address phase, then data phase, each ends on hready
            do @(posedge CLOCK); while (hready !== 1'h1);
            htrans <= 2'h0;
            hwdata <= wd;
        end
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        chk(r, e);
        chk(hresp, 32'h0);
    endtask
    task automatic hit(input logic up);
        @(posedge CLOCK);
        au <= up;
        bl <= !up;
        @(posedge CLOCK);
        au <= 1'h0;
        bl <= 1'h0;
    endtask
    // 80 means no flag seen, longer than the dual window
    task automatic wait_flag(output int n);
        n = 0;
        do begin @(posedge CLOCK); n++; end while (flag !== 1'h1 && n < 80);
    endtask
    task automatic wait_end;
        int p;
        p = pulses;
        while (pulses == p) @(posedge CLOCK);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({flag, lamp, irq}, 32'h0);
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_TRIM, 32'h80);
        rd(ADDR_IRQ_MASK, 32'h0);
        rd(ADDR_STATUS, 32'h2);
        wr(8'h40, 32'hFFFF);
        rd(8'h40, 32'h0);
    endtask
    task automatic t_startup;
        int rises;
        logic l;
        logic fl;
        rises = 0;
        fl = 1'h0;
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_IRQ_MASK, 32'h4);
        hit(1'h1);
        l = lamp;
        while (irq !== 1'h1 && cyc - t0 < 3000)
        begin
            @(posedge CLOCK);
            rises += (lamp === 1'h1 && l === 1'h0);
            l = lamp;
            fl |= flag;
        end
        rng(cyc - t0, STT * 12, STT * 12 + 16);
        chk(rises, 1);
        chk(fl, 1'h0);
        wr(ADDR_IRQ_STAT, 32'h4);
        wr(ADDR_IRQ_MASK, 32'h0);
        rd(ADDR_IRQ_STAT, 32'h0);
        rd(ADDR_STATUS, 32'h0);
    endtask
    task automatic t_pulse;
        logic [7:0] tr [3] = '{8'h00, 8'h80, 8'hFF};
        int n;
        int pe;
        wr(ADDR_CTRL, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_TRIM, {24'h0, tr[i]});
            rd(ADDR_TRIM, {24'h0, tr[i]});
            pe = int'(OMIN) + int'(OMAX - OMIN) * int'(tr[i]) / 255;
            hit(i != 1);
            wait_flag(n);
            rng(n, 1, 2);
            chk(lamp, 1'h1);
            wait_end();
            rng(len, PULSE_TICKS * pe, PULSE_TICKS * pe + 2);
            chk(lamp, 1'h0);
        end
        rd(ADDR_IRQ_STAT, 32'h3);
        wr(ADDR_IRQ_MASK, 32'h3);
        repeat (2) @(posedge CLOCK);
        chk(irq, 1'h1);
        wr(ADDR_IRQ_STAT, 32'h3);
        repeat (2) @(posedge CLOCK);
        chk(irq, 1'h0);
    endtask
    task automatic t_dual;
        int n;
        wr(ADDR_TRIM, 32'h0);
        wr(ADDR_CTRL, 32'h3);
        hit(1'h1);
        wait_flag(n);
        chk(n, 80);
        hit(1'h0);
        repeat (10) @(posedge CLOCK);
        chk(flag, 1'h0);
        hit(1'h1);
        wait_flag(n);
        rng(n, 1, 2);
        chk(lamp, 1'h0);
        wait_end();
        wr(ADDR_CTRL, 32'h0);
    endtask
    // second crossing 103 clocks into a pulse restarts its tick count
    task automatic t_retrig;
        int n;
        hit(1'h1);
        wait_flag(n);
        rng(n, 1, 2);
        repeat (100) @(posedge CLOCK);
        hit(1'h0);
        wait_end();
        rng(len, 103 + PULSE_TICKS * int'(OMIN), 105 + PULSE_TICKS * int'(OMIN));
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge CLOCK);
        mismatches++;
        summarize();
    end
    initial
    begin
        repeat (3) @(posedge CLOCK);
        RST_N <= 1'h1;
        t0 = cyc;
        t_reset();
        t_startup();
        t_pulse();
        t_dual();
        t_retrig();
        summarize();
    end
endmodule
